// File: include/ripple_pkg.sv
// Shared constants, register map and carrier types of the dual ripple counter.
package ripple_pkg;

  // Counter geometry.
  localparam int COUNT_W      = 5;
  localparam int NUM_COUNTERS = 2;

  // Modulo-20 wrap: both of these stages high forces the counter back to zero.
  localparam int MOD_HI_BIT = 4;
  localparam int MOD_LO_BIT = 2;

  // Register port geometry.
  localparam int ADDR_W     = 4;
  localparam int DATA_W_DEF = 16;

  // Register offsets.
  localparam logic [ADDR_W-1:0] CTRL_ADDR          = 4'h0;
  localparam logic [ADDR_W-1:0] PRESET_FIRST_ADDR  = 4'h1;
  localparam logic [ADDR_W-1:0] PRESET_SECOND_ADDR = 4'h2;
  localparam logic [ADDR_W-1:0] STATUS_ADDR        = 4'h3;
  localparam logic [ADDR_W-1:0] COUNT_ADDR         = 4'h4;

  // Control register fields and reset values.
  localparam int                   CTRL_MOD20_FIRST_BIT  = 0;
  localparam int                   CTRL_MOD20_SECOND_BIT = 1;
  localparam int                   CTRL_W                = 2;
  localparam logic [CTRL_W-1:0]    CTRL_RESET            = 2'h0;
  localparam logic [COUNT_W-1:0]   PRESET_RESET          = 5'h00;

  // Worst-case ripple: the edge step plus one clock per stage.
  localparam int RIPPLE_SETTLE_CYCLES = COUNT_W + 1;

  // Everything one counter needs from the control side.
  typedef struct packed {
    logic               hold;
    logic               mod20;
    logic               load;
    logic [COUNT_W-1:0] load_value;
  } counter_ctl_s;

endpackage : ripple_pkg

// File: tb/dual_ripple_counter_tb.sv
// Self-checking testbench of the dual ripple counter, driven through its ports.
module dual_ripple_counter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ripple_pkg::*;

  localparam int SETTLE    = RIPPLE_SETTLE_CYCLES + 2;
  localparam int MAX_TICKS = 3000;

  logic                clk_i                = 1'b0;
  logic                reset_i              = 1'b1;
  logic                clear_i              = 1'b0;
  logic                count_clock_first_i  = 1'b0;
  logic                count_clock_second_i = 1'b0;
  logic                hold_first_i         = 1'b0;
  logic                hold_second_i        = 1'b0;
  logic [ADDR_W-1:0]   addr_i               = 4'h0;
  logic [15:0]         wdata_i              = 16'h0000;
  logic                wr_i                 = 1'b0;
  logic                rd_i                 = 1'b0;
  logic [15:0]         rdata_o;
  logic [COUNT_W-1:0]  first_count_o;
  logic [COUNT_W-1:0]  second_count_o;
  logic                first_settled_o;
  logic                second_settled_o;
  int                  err_count            = 0;
  int                  check_count          = 0;
  int                  ticks                = 0;

  dual_ripple_counter #(.DATA_W(16)) dut (
    .clk_i(clk_i), .reset_i(reset_i), .clear_i(clear_i),
    .count_clock_first_i(count_clock_first_i), .count_clock_second_i(count_clock_second_i),
    .hold_first_i(hold_first_i), .hold_second_i(hold_second_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .first_count_o(first_count_o), .second_count_o(second_count_o),
    .first_settled_o(first_settled_o), .second_settled_o(second_settled_o)
  );

  always #2.5 clk_i = ~clk_i;

  task automatic close_out;
    $display("Checks made %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  // A hang shows up as a run far longer than the sequence needs.
  always @(posedge clk_i)
  begin
    ticks++;
    if (ticks >= MAX_TICKS)
    begin
      err_count++;
      $display("CHECK FAILED run length expected below %0d seen %0d", MAX_TICKS, ticks);
      close_out();
    end
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : reg_write

  task automatic reg_check(input string what, input logic [ADDR_W-1:0] a,
                           input logic [15:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    check(what, exp, rdata_o);
  endtask : reg_check

  // Counts are only compared once the ripple has had time to settle.
  task automatic expect_counts(input logic [COUNT_W-1:0] a, input logic [COUNT_W-1:0] b);
    check("first count", 16'(a), 16'(first_count_o));
    check("second count", 16'(b), 16'(second_count_o));
    check("settled flags", 16'h0003, {14'h0000, second_settled_o, first_settled_o});
  endtask : expect_counts

  task automatic pulse(input logic a, input logic b);
    @(posedge clk_i);
    count_clock_first_i  <= a;
    count_clock_second_i <= b;
    @(posedge clk_i);
    count_clock_first_i  <= 1'b0;
    count_clock_second_i <= 1'b0;
    repeat (SETTLE) @(posedge clk_i);
    #1;
  endtask : pulse

  task automatic preset_both(input logic [COUNT_W-1:0] a, input logic [COUNT_W-1:0] b);
    reg_write(PRESET_FIRST_ADDR, 16'(a));
    reg_write(PRESET_SECOND_ADDR, 16'(b));
    repeat (3) @(posedge clk_i);
    #1;
  endtask : preset_both

  initial
  begin
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    #1;
    expect_counts(5'h00, 5'h00);
    check("idle read data", 16'h0000, rdata_o);
    reg_check("control reset", CTRL_ADDR, 16'h0000);
    reg_check("first preset reset", PRESET_FIRST_ADDR, 16'h0000);
    reg_check("second preset reset", PRESET_SECOND_ADDR, 16'h0000);
    reg_check("status idle", STATUS_ADDR, 16'h0003);
    for (int i = 1; i <= 5; i++)
    begin
      pulse(1'b1, 1'b1);
      expect_counts(COUNT_W'(i), COUNT_W'(i));
    end
    @(posedge clk_i);
    hold_first_i <= 1'b1;
    pulse(1'b1, 1'b1);
    expect_counts(5'h05, 5'h06);
    @(posedge clk_i);
    hold_first_i  <= 1'b0;
    hold_second_i <= 1'b1;
    pulse(1'b1, 1'b1);
    expect_counts(5'h06, 5'h06);
    @(posedge clk_i);
    hold_second_i <= 1'b0;
    // A carry through four stages is the longest ripple either counter can see.
    preset_both(5'h0F, 5'h0F);
    expect_counts(5'h0F, 5'h0F);
    @(posedge clk_i);
    count_clock_first_i <= 1'b1;
    @(posedge clk_i);
    count_clock_first_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    check("settled during carry", 16'h0000, 16'(first_settled_o));
    repeat (SETTLE) @(posedge clk_i);
    #1;
    expect_counts(5'h10, 5'h0F);
    pulse(1'b0, 1'b1);
    expect_counts(5'h10, 5'h10);
    for (int m = 1; m <= 2; m++)
    begin
      reg_write(CTRL_ADDR, 16'(m));
      preset_both(5'h13, 5'h13);
      pulse(1'b1, 1'b1);
      expect_counts((m == 1) ? 5'h00 : 5'h14, (m == 1) ? 5'h14 : 5'h00);
    end
    reg_check("preset readback", PRESET_FIRST_ADDR, 16'h0013);
    reg_check("count word", COUNT_ADDR, 16'h0014);
    reg_write(COUNT_ADDR, 16'h03FF);
    reg_write(4'hF, 16'hFFFF);
    reg_check("count after write", COUNT_ADDR, 16'h0014);
    reg_check("control kept", CTRL_ADDR, 16'h0002);
    reg_check("unmapped read", 4'hF, 16'h0000);
    @(posedge clk_i);
    clear_i <= 1'b1;
    #1;
    check("counts under clear", 16'h0000, {6'h00, second_count_o, first_count_o});
    @(posedge clk_i);
    clear_i <= 1'b0;
    pulse(1'b1, 1'b1);
    expect_counts(5'h01, 5'h01);
    close_out();
  end

endmodule : dual_ripple_counter_tb

// File: verilog/dual_ripple_counter.sv
// Two independent five-stage binary ripple counters with shared clear and register port.
//
// Notes on behaviour
// R1 - Each counter is five stages of plain binary, stage zero least significant.
// R2 - Stages share no count clock; each higher stage is clocked from the stage below.
// R3 - A higher stage toggles when the stage below goes from one to zero.
// R4 - Stage zero of the first counter toggles on each rising edge of its count clock.
// R5 - With hold high every clocked stage keeps its value; with hold low it inverts.
// R6 - The second counter has the same structure, its own clock and hold, and is independent.
// R7 - The shared clear forces all stages of both counters to zero at once; outputs always drive.
// R8 - From zero with hold low, each count clock rising edge advances the value by one.
// R9 - The value is valid only after the change has rippled through all five stages.
// R10 - Each stage can be forced to a chosen value to restart the count.
// R11 - In modulo-20 mode a counter returns to zero as soon as bits 4 and 2 are both high.
// R12 - The outside keeps clear low while counting and samples only settled values.
//
// The ripple is emulated on the system clock: each stage clock term is a one-cycle
// pulse that reaches the next stage one clock later, so a carry through all five
// stages takes five clocks after the edge is seen.
module dual_ripple_counter
  import ripple_pkg::*;
#(
  parameter int DATA_W = ripple_pkg::DATA_W_DEF
) (
  input  wire logic                          clk_i,                // System clock, 200 MHz.
  input  wire logic                          reset_i,              // Async reset, active high.
  input  wire logic                          clear_i,              // Shared async clear.
  input  wire logic                          count_clock_first_i,  // First count clock.
  input  wire logic                          count_clock_second_i, // Second count clock.
  input  wire logic                          hold_first_i,         // First counter hold.
  input  wire logic                          hold_second_i,        // Second counter hold.
  input  wire logic [ripple_pkg::ADDR_W-1:0] addr_i,               // Register address.
  input  wire logic [DATA_W-1:0]             wdata_i,              // Register write data.
  input  wire logic                          wr_i,                 // Write strobe.
  input  wire logic                          rd_i,                 // Read strobe.
  output logic      [DATA_W-1:0]             rdata_o,              // Read data, next cycle.
  output logic      [ripple_pkg::COUNT_W-1:0] first_count_o,       // First counter value.
  output logic      [ripple_pkg::COUNT_W-1:0] second_count_o,      // Second counter value.
  output logic                               first_settled_o,      // First ripple finished.
  output logic                               second_settled_o      // Second ripple finished.
);

  import ripple_pkg::*;

  if (DATA_W < 2 * COUNT_W)
  begin : g_bad_width
    $error("DATA_W must hold both counter values");
  end

  localparam logic [ADDR_W-1:0] PRESET_ADDR [NUM_COUNTERS] =
    '{PRESET_FIRST_ADDR, PRESET_SECOND_ADDR};

  // Register state.
  logic [CTRL_W-1:0]       ctrl_reg;
  logic [COUNT_W-1:0]      preset_reg [NUM_COUNTERS];
  logic [NUM_COUNTERS-1:0] load_reg;
  logic [NUM_COUNTERS-1:0] settled_reg;
  logic [DATA_W-1:0]       rdata_reg;

  // Counter datapath.
  counter_ctl_s            ctl   [NUM_COUNTERS];
  logic [COUNT_W-1:0]      cnt   [NUM_COUNTERS];
  logic [COUNT_W-1:0]      fall  [NUM_COUNTERS];
  logic [NUM_COUNTERS-1:0] rise;
  logic [NUM_COUNTERS-1:0] wipe;
  logic [NUM_COUNTERS-1:0] busy;
  logic [NUM_COUNTERS-1:0] level_in;
  logic [NUM_COUNTERS-1:0] hold_in;
  logic [NUM_COUNTERS-1:0] mod20_in;
  logic [NUM_COUNTERS-1:0] wr_preset;

  // Register decode.
  logic              wr_ctrl;
  logic [DATA_W-1:0] ctrl_word;
  logic [DATA_W-1:0] preset_first_word;
  logic [DATA_W-1:0] preset_second_word;
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] count_word;
  logic [DATA_W-1:0] rd_word;

  assign level_in = {count_clock_second_i, count_clock_first_i};
  assign hold_in  = {hold_second_i, hold_first_i};
  assign mod20_in = {ctrl_reg[CTRL_MOD20_SECOND_BIT], ctrl_reg[CTRL_MOD20_FIRST_BIT]};
  assign wr_ctrl  = wr_i && (addr_i == CTRL_ADDR);

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      ctrl_reg <= CTRL_RESET;
    else if (wr_ctrl)
      ctrl_reg <= wdata_i[CTRL_W-1:0];
  end

  // One counter per iteration; both are built alike and share only the clear, the reset and the register port.
  for (genvar c = 0; c < NUM_COUNTERS; c++)
  begin : g_counter
    logic edge_rise;

    assign wr_preset[c] = wr_i && (addr_i == PRESET_ADDR[c]);

    always_ff @(posedge clk_i or posedge reset_i)
    begin
      if (reset_i)
      begin
        preset_reg[c] <= PRESET_RESET;
        load_reg[c]   <= 1'b0;
      end
      else
      begin
        if (wr_preset[c])
          preset_reg[c] <= wdata_i[COUNT_W-1:0];
        load_reg[c] <= wr_preset[c]; // R10
      end
    end

    assign ctl[c].hold       = hold_in[c]; // R5
    assign ctl[c].mod20      = mod20_in[c];
    assign ctl[c].load       = load_reg[c];
    assign ctl[c].load_value = preset_reg[c];

    ripple_edge u_edge (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .level_i (level_in[c]),
      .rise_o  (edge_rise)
    );
    assign rise[c] = edge_rise; // R4 R6

    // The wrap decodes the live stage outputs, like a product term on the reset.
    assign wipe[c] = ctl[c].mod20 & cnt[c][MOD_HI_BIT] & cnt[c][MOD_LO_BIT]; // R11

    for (genvar s = 0; s < COUNT_W; s++)
    begin : g_stage
      logic stage_clock_term;
      logic stage_q;
      logic stage_fall;

      if (s == 0)
      begin : g_lsb
        assign stage_clock_term = rise[c]; // R4 R8
      end
      else
      begin : g_upper
        // Clocked by the inverted output of the stage below.
        assign stage_clock_term = fall[c][s-1]; // R2 R3
      end

      ripple_stage u_stage (
        .clk_i        (clk_i),
        .reset_i      (reset_i),
        .clear_i      (clear_i), // R7
        .toggle_i     (stage_clock_term),
        .hold_i       (ctl[c].hold),
        .load_i       (ctl[c].load),
        .load_value_i (ctl[c].load_value[s]),
        .wipe_i       (wipe[c]),
        .q_o          (stage_q),
        .fall_o       (stage_fall)
      );
      assign cnt[c][s]  = stage_q;    // R1
      assign fall[c][s] = stage_fall;
    end

    // A carry out of the top stage goes nowhere, so its pulse is not activity.
    assign busy[c] = rise[c] | (|fall[c][COUNT_W-2:0]) | ctl[c].load | wipe[c];
  end

  // Settled means no edge, carry, load or wrap is still in flight.
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      settled_reg <= '1;
    else
      settled_reg <= ~busy; // R9
  end

  // Read mux; unmapped addresses read as zero.
  assign ctrl_word          = DATA_W'(ctrl_reg);
  assign preset_first_word  = DATA_W'(preset_reg[0]);
  assign preset_second_word = DATA_W'(preset_reg[1]);
  assign status_word        = DATA_W'(settled_reg);
  assign count_word         = DATA_W'({cnt[1], cnt[0]});
  assign rd_word = (addr_i == CTRL_ADDR)          ? ctrl_word :
                   (addr_i == PRESET_FIRST_ADDR)  ? preset_first_word :
                   (addr_i == PRESET_SECOND_ADDR) ? preset_second_word :
                   (addr_i == STATUS_ADDR)        ? status_word :
                   (addr_i == COUNT_ADDR)         ? count_word : '0;

  // Data stand only in the cycle after the strobe, zero otherwise.
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      rdata_reg <= '0;
    else if (rd_i)
      rdata_reg <= rd_word;
    else
      rdata_reg <= '0;
  end

  // Counter outputs are the stage flip-flops themselves and drive at all times.
  assign first_count_o    = cnt[0]; // R7
  assign second_count_o   = cnt[1];
  assign first_settled_o  = settled_reg[0];
  assign second_settled_o = settled_reg[1];
  assign rdata_o          = rdata_reg;

  // All checks except clear_zero_a pause under reset or the shared clear, since the clear moves every stage at
  // once with no clock behind it; clear_zero_a pauses under reset only.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i || clear_i);

  stage0_toggle_a: assert property ( // R4
    rise[0] && !hold_in[0] && !load_reg[0] && !wipe[0]
      |=> cnt[0][0] != $past(cnt[0][0]))
    else $error("first counter stage zero missed an edge");

  hold_keeps_a: assert property ( // R5
    hold_in[0] && !load_reg[0] && !wipe[0] |=> cnt[0] == $past(cnt[0]))
    else $error("first counter changed while held");

  ripple_step_a: assert property ( // R3
    fall[0][0] && !hold_in[0] && !load_reg[0] && !wipe[0]
      |=> cnt[0][1] != $past(cnt[0][1]))
    else $error("stage one did not toggle on stage zero falling");

  no_shared_clock_a: assert property ( // R2
    !fall[0][0] && !load_reg[0] && !wipe[0] |=> $stable(cnt[0][1]))
    else $error("stage one changed without a stage zero fall");

  second_toggle_a: assert property ( // R6
    rise[1] && !hold_in[1] && !load_reg[1] && !wipe[1]
      |=> cnt[1][0] != $past(cnt[1][0]))
    else $error("second counter stage zero missed an edge");

  mod20_wrap_a: assert property ( // R11
    mod20_in[0] && cnt[0][MOD_HI_BIT] && cnt[0][MOD_LO_BIT] && !load_reg[0]
      |=> cnt[0] == 5'h00)
    else $error("modulo-20 wrap did not clear the first counter");

  // Seven cycles back is the value before the edge: the settled flag lags by one cycle and
  // the edge plus the longest carry take six more.
  count_step_a: assert property ( // R8
    (settled_reg[0] && rise[0] && !hold_in[0] && !load_reg[0] && !mod20_in[0])
      ##1 (!rise[0] && !hold_in[0] && !load_reg[0] && !wr_i)[*6]
      |-> cnt[0] == COUNT_W'($past(cnt[0], 7) + 5'h01))
    else $error("first counter did not advance by one");

  settle_bound_a: assert property ( // R9
    rise[0] ##1 (!rise[0] && !load_reg[0] && !wipe[0])[*6] |-> settled_reg[0])
    else $error("first counter still rippling after five stages");

  clear_zero_a: assert property ( // R7
    @(posedge clk_i) disable iff (reset_i)
    clear_i |-> cnt[0] == 5'h00 && cnt[1] == 5'h00)
    else $error("clear did not zero both counters");

  preset_load_a: assert property ( // R10
    load_reg[0] |=> cnt[0] == $past(preset_reg[0]))
    else $error("preset value not taken by the first counter");

  // Stage four has no stage above it, so its carry is checked on its own input.
  top_ripple_a: assert property ( // R3
    fall[0][3] && !hold_in[0] && !load_reg[0] && !wipe[0]
      |=> cnt[0][4] != $past(cnt[0][4]))
    else $error("first counter stage four missed its carry");

  top_stage_a: assert property ( // R2
    !fall[0][3] && !load_reg[0] && !wipe[0] |=> $stable(cnt[0][4]))
    else $error("stage four changed without a stage three fall");

  // A quiet counter must not move, whatever the other counter is doing.
  first_quiet_a: assert property ( // R6
    !busy[0] |=> $stable(cnt[0]))
    else $error("first counter changed while nothing was in flight");

  second_quiet_a: assert property ( // R6
    !busy[1] |=> $stable(cnt[1]))
    else $error("second counter changed while nothing was in flight");

  second_hold_a: assert property ( // R5
    hold_in[1] && !load_reg[1] && !wipe[1] |=> cnt[1] == $past(cnt[1]))
    else $error("second counter changed while held");

  second_ripple_a: assert property ( // R3
    fall[1][0] && !hold_in[1] && !load_reg[1] && !wipe[1]
      |=> cnt[1][1] != $past(cnt[1][1]))
    else $error("second counter stage one did not toggle on stage zero falling");

  second_top_a: assert property ( // R3
    fall[1][3] && !hold_in[1] && !load_reg[1] && !wipe[1]
      |=> cnt[1][4] != $past(cnt[1][4]))
    else $error("second counter stage four missed its carry");

  second_step_a: assert property ( // R8
    (settled_reg[1] && rise[1] && !hold_in[1] && !load_reg[1] && !mod20_in[1])
      ##1 (!rise[1] && !hold_in[1] && !load_reg[1] && !wr_i)[*6]
      |-> cnt[1] == COUNT_W'($past(cnt[1], 7) + 5'h01))
    else $error("second counter did not advance by one");

  second_wrap_a: assert property ( // R11
    mod20_in[1] && cnt[1][MOD_HI_BIT] && cnt[1][MOD_LO_BIT] && !load_reg[1]
      |=> cnt[1] == 5'h00)
    else $error("modulo-20 wrap did not clear the second counter");

  second_preset_a: assert property ( // R10
    load_reg[1] |=> cnt[1] == $past(preset_reg[1]))
    else $error("preset value not taken by the second counter");

  // Register side: what software writes is what the counters later use.
  preset_write_a: assert property ( // R10
    wr_preset[0] |=> preset_reg[0] == $past(wdata_i[COUNT_W-1:0]))
    else $error("first preset write did not land");

  second_write_a: assert property ( // R10
    wr_preset[1] |=> preset_reg[1] == $past(wdata_i[COUNT_W-1:0]))
    else $error("second preset write did not land");

  ctrl_write_a: assert property ( // R11
    wr_ctrl |=> ctrl_reg == $past(wdata_i[CTRL_W-1:0]))
    else $error("control write did not land");

  count_read_a: assert property ( // R1
    rd_i && addr_i == COUNT_ADDR
      |=> rdata_reg == DATA_W'({$past(cnt[1]), $past(cnt[0])}))
    else $error("count read did not return both counter values");

  status_read_a: assert property ( // R9
    rd_i && addr_i == STATUS_ADDR |=> rdata_reg == DATA_W'($past(settled_reg)))
    else $error("status read did not return the settled flags");

  // Scenarios the bench should reach: a wrap on each counter, a carry into the top stage and the end
  // of a ripple on the first counter, and a held edge on the second counter.
  wrap_seen_c: cover property (mod20_in[0] && wipe[0] ##1 cnt[0] == 5'h00);

  full_ripple_c: cover property (fall[0][3] ##1 cnt[0][4]);

  hold_edge_c: cover property (rise[1] && hold_in[1]);

  settle_seen_c: cover property (!settled_reg[0] ##1 settled_reg[0]);

  second_wrap_c: cover property (mod20_in[1] && wipe[1] ##1 cnt[1] == 5'h00);

endmodule : dual_ripple_counter

// File: verilog/ripple_edge.sv
// Rising-edge detector for an external count clock sampled by the system clock.
module ripple_edge (
  input  wire logic clk_i,   // System clock.
  input  wire logic reset_i, // Asynchronous reset, active high.
  input  wire logic level_i, // Count clock level, synchronous to clk_i.
  output logic      rise_o   // One-cycle pulse on a low-to-high change.
);

  logic prev_reg;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      prev_reg <= 1'b0;
    else
      prev_reg <= level_i;
  end

  assign rise_o = level_i & ~prev_reg;

endmodule : ripple_edge

// File: verilog/ripple_stage.sv
// One toggle stage of a ripple counter with clear, load and hold.
module ripple_stage (
  input  wire logic clk_i,        // System clock.
  input  wire logic reset_i,      // Asynchronous reset, active high.
  input  wire logic clear_i,      // Shared asynchronous clear, active high.
  input  wire logic toggle_i,     // Stage clock term: one-cycle toggle request.
  input  wire logic hold_i,       // Keep value when clocked.
  input  wire logic load_i,       // Restart from load_value_i.
  input  wire logic load_value_i, // Value taken on load.
  input  wire logic wipe_i,       // Modulo wrap back to zero.
  output logic      q_o,          // Stage output.
  output logic      fall_o        // One-cycle pulse after a one-to-zero toggle.
);

  logic q_reg;
  logic q_next;
  logic fall_reg;
  logic fall_next;

  // Load wins over wrap so that software can always restart the count.
  assign q_next    = load_i ? load_value_i :
                     wipe_i ? 1'b0 :
                     (toggle_i && !hold_i) ? ~q_reg : q_reg;
  // Forced changes must not clock the stage above, or a wrap would count.
  assign fall_next = q_reg & ~q_next & ~load_i & ~wipe_i;

  always_ff @(posedge clk_i or posedge reset_i or posedge clear_i)
  begin
    if (reset_i || clear_i)
    begin
      q_reg    <= 1'b0;
      fall_reg <= 1'b0;
    end
    else
    begin
      q_reg    <= q_next;
      fall_reg <= fall_next;
    end
  end

  assign q_o    = q_reg;
  assign fall_o = fall_reg;

endmodule : ripple_stage
